/* File: hw/rcas_btn.sv */
// button debouncer and short/long press classifier
`timescale 1ns/1ps
`default_nettype none
module rcas_btn #(
	parameter int N          = rcas_pkg::BTN_N,
	parameter int DEB_TICKS  = rcas_pkg::DEB_TICKS,
	parameter int LONG_TICKS = rcas_pkg::LONG_TICKS
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// buttons
	rcas_btn_if.btn_mp bi
);
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_btn
			logic        stable;
			logic [15:0] deb_cnt;
			logic [15:0] hold_cnt;
			logic        is_long;
			logic        sp;
			logic        lp;
			logic        lrp;

			// a level must stand for the debounce time before it counts
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					stable  <= 1'b0;
					deb_cnt <= 16'h0;
				end else if (bi.tick) begin
					if (bi.raw[g] == stable) begin
						deb_cnt <= 16'h0;
					end else if (deb_cnt == 16'(DEB_TICKS - 1)) begin
						deb_cnt <= 16'h0;
						stable  <= bi.raw[g];
					end else begin
						deb_cnt <= deb_cnt + 16'h1;
					end
				end
			end

			// long at the threshold, short on an early release
			always_ff @(posedge clk_i) begin
				if (rst_i) begin
					hold_cnt <= 16'h0;
					is_long  <= 1'b0;
					sp       <= 1'b0;
					lp       <= 1'b0;
					lrp      <= 1'b0;
				end else begin
					sp  <= 1'b0;
					lp  <= 1'b0;
					lrp <= 1'b0;
					if (bi.tick) begin
						if (stable) begin
							if (!is_long && hold_cnt == 16'(LONG_TICKS - 1)) begin
								is_long <= 1'b1;
								lp      <= 1'b1;
							end else if (!is_long) begin
								hold_cnt <= hold_cnt + 16'h1;
							end
						end else begin
							sp       <= (hold_cnt != 16'h0) && !is_long;
							lrp      <= is_long;
							hold_cnt <= 16'h0;
							is_long  <= 1'b0;
						end
					end
				end
			end

			assign bi.short_p[g]    = sp;
			assign bi.long_p[g]     = lp;
			assign bi.long_rel_p[g] = lrp;
			assign bi.long_held[g]  = is_long;
		end
	endgenerate
endmodule
`default_nettype wire

/* File: hw/rcas_btn_if.sv */
// interface: time base and button events shared by the supervisor's modules
`timescale 1ns/1ps
`default_nettype none
interface rcas_btn_if #(parameter int N = 5);
	logic         tick;
	logic         flash;
	logic [N-1:0] raw;
	logic [N-1:0] short_p;
	logic [N-1:0] long_p;
	logic [N-1:0] long_rel_p;
	logic [N-1:0] long_held;

	modport tick_mp (output tick, output flash);
	modport btn_mp  (input tick, input raw,
		output short_p, output long_p, output long_rel_p, output long_held);
	modport core_mp (input tick, input flash, output raw,
		input short_p, input long_p, input long_rel_p, input long_held);
endinterface
`default_nettype wire

/* File: hw/rcas_pkg.sv */
// package: constants and types of the residual current alarm supervisor
package rcas_pkg;
	// clock and time base
	localparam int CLK_PERIOD_NS  = 100;
	localparam int TICK_PERIOD_NS = 1_000_000;
	localparam int TICK_CYC       = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TICK_MS        = 1;
	// timing figures in their own units, then in ticks
	localparam int LONG_PRESS_MS  = 1500;
	localparam int LONG_TICKS     = LONG_PRESS_MS / TICK_MS;
	localparam int DEBOUNCE_MS    = 20;
	localparam int DEB_TICKS      = DEBOUNCE_MS / TICK_MS;
	localparam int CT_CHECK_S     = 10;
	localparam int CT_TICKS       = CT_CHECK_S * 1000 / TICK_MS;
	localparam int AUTO_TEST_H    = 24;
	localparam int AUTO_TICKS     = AUTO_TEST_H * 3600 * 1000 / TICK_MS;
	localparam int POST_MS        = 500;
	localparam int POST_TICKS     = POST_MS / TICK_MS;
	localparam int FLASH_MS       = 250;
	localparam int FLASH_TICKS    = FLASH_MS / TICK_MS;
	// currents in microamps
	localparam logic [16:0] TRIP_UA = 17'h01770;
	localparam logic [16:0] TEST_UA = 17'h01B58;
	// button indices
	localparam int BTN_N     = 5;
	localparam int BTN_UP    = 0;
	localparam int BTN_DOWN  = 1;
	localparam int BTN_ENTER = 2;
	localparam int BTN_XTEST = 3;
	localparam int BTN_XRST  = 4;
	// register byte offsets
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MEAS   = 8'h08;
	localparam logic [7:0] REG_HIST   = 8'h0C;
	localparam logic [7:0] REG_CFG    = 8'h10;
	localparam logic [7:0] REG_PWSET  = 8'h14;
	localparam logic [7:0] REG_PWKEY  = 8'h18;
	// control bit positions
	localparam int CTRL_RESET   = 0;
	localparam int CTRL_FACTORY = 1;
	localparam int CTRL_HCLR    = 2;
	localparam int CTRL_LOCK    = 3;
	localparam int PWSET_EN     = 16;
	// values after reset and delivery defaults
	localparam logic [15:0] CLR_WIN_DEF = 16'h00C8;
	localparam logic [7:0]  ADDR_DEF    = 8'h03;
	localparam logic [9:0]  PW_DEF      = 10'h000;
	localparam logic [9:0]  PW_MAX      = 10'h3E7;
	// error codes
	localparam logic [3:0] ERR_NONE  = 4'h0;
	localparam logic [3:0] ERR_SHORT = 4'h1;
	localparam logic [3:0] ERR_OPEN  = 4'h3;
	localparam logic [3:0] ERR_CONT  = 4'h4;
	localparam logic [3:0] ERR_INT   = 4'h5;

	typedef enum logic [1:0] {
		ST_POST  = 2'b00,
		ST_RUN   = 2'b01,
		ST_MTEST = 2'b11
	} rcas_state_t;

	typedef enum logic [2:0] {
		DSP_MEAS   = 3'h0,
		DSP_THRESH = 3'h1,
		DSP_ALLSEG = 3'h2,
		DSP_TEST   = 3'h3,
		DSP_ERROR  = 3'h4
	} rcas_disp_t;
endpackage

/* File: hw/rcas_tick.sv */
// time base: millisecond tick and indicator flash phase
`timescale 1ns/1ps
`default_nettype none
module rcas_tick #(
	parameter int TICK_CYC = rcas_pkg::TICK_CYC
) (
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rst_i,
	// time base
	rcas_btn_if.tick_mp tb
);
	logic [31:0] cyc_cnt;
	logic [31:0] fl_cnt;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cyc_cnt <= 32'h0;
			tb.tick <= 1'b0;
		end else if (cyc_cnt == 32'(TICK_CYC - 1)) begin
			cyc_cnt <= 32'h0;
			tb.tick <= 1'b1;
		end else begin
			cyc_cnt <= cyc_cnt + 32'h1;
			tb.tick <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fl_cnt   <= 32'h0;
			tb.flash <= 1'b0;
		end else if (tb.tick) begin
			if (fl_cnt == 32'(rcas_pkg::FLASH_TICKS - 1)) begin
				fl_cnt   <= 32'h0;
				tb.flash <= ~tb.flash;
			end else begin
				fl_cnt <= fl_cnt + 32'h1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: hw/rcas_top.sv */
// supervisor core: trip logic, self tests, indicators and register file
//
// The address map and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rcas_top #(
	parameter int TICK_CYC   = rcas_pkg::TICK_CYC,
	parameter int LONG_TICKS = rcas_pkg::LONG_TICKS,
	parameter int DEB_TICKS  = rcas_pkg::DEB_TICKS,
	parameter int CT_TICKS   = rcas_pkg::CT_TICKS,
	parameter int AUTO_TICKS = rcas_pkg::AUTO_TICKS,
	parameter int POST_TICKS = rcas_pkg::POST_TICKS
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// measurement and monitors
	input  wire logic [15:0] residual_ua_i,
	input  wire logic        ct_short_i,
	input  wire logic        ct_open_i,
	input  wire logic        int_fault_i,
	// buttons, high while pressed
	input  wire logic        btn_up_i,
	input  wire logic        btn_down_i,
	input  wire logic        btn_enter_i,
	input  wire logic        ext_test_i,
	input  wire logic        ext_reset_i,
	// relay, lamps and display
	output logic             alarm_relay_o,
	output logic             trip_lamp_o,
	output logic             err_lamp_o,
	output logic             test_inject_o,
	output logic             menu_mode_o,
	output logic      [2:0]  disp_sel_o,
	output logic      [15:0] disp_value_o,
	output logic      [3:0]  err_code_o
);
	rcas_btn_if #(.N(rcas_pkg::BTN_N)) bif ();

	rcas_tick #(.TICK_CYC(TICK_CYC)) u_tick (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.tb    (bif.tick_mp)
	);

	rcas_btn #(
		.N          (rcas_pkg::BTN_N),
		.DEB_TICKS  (DEB_TICKS),
		.LONG_TICKS (LONG_TICKS)
	) u_btn (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.bi    (bif.btn_mp)
	);

	assign bif.raw = {ext_reset_i, ext_test_i, btn_enter_i, btn_down_i, btn_up_i};

	////////////////////////////////////////////////////////////////////////
	rcas_pkg::rcas_state_t state;
	rcas_pkg::rcas_disp_t  disp;
	logic [31:0] post_cnt;
	logic [31:0] ct_cnt;
	logic [31:0] auto_cnt;
	logic [15:0] clr_cnt;
	logic        clr_run;
	logic        alarm;
	logic        alarm_d;
	logic        ct_err;
	logic [3:0]  ct_code;
	logic        cont_err;
	logic        int_err;
	logic        inj;
	logic        mtest_done;
	logic        quick;
	logic        menu;
	logic [16:0] eval_ua;
	logic        over;
	logic        meas_over;
	logic        reset_req;
	logic        test_start;
	logic        bus_req;
	logic        bus_wr;
	logic [3:0]  ctrl_wr;
	logic        cfg_ok;
	logic [15:0] clr_win;
	logic [7:0]  dev_addr;
	logic [9:0]  pw_val;
	logic        pw_en;
	logic        unlocked;
	logic [15:0] hist_val;
	logic        hist_vld;

	// the injected test current adds to the live reading, never replaces it
	assign eval_ua   = {1'b0, residual_ua_i} + (inj ? rcas_pkg::TEST_UA : 17'h0);
	assign over      = eval_ua > rcas_pkg::TRIP_UA;
	assign meas_over = {1'b0, residual_ua_i} >= rcas_pkg::TRIP_UA;

	// either the front or the external button acts
	assign reset_req = bif.long_p[rcas_pkg::BTN_DOWN] | bif.long_p[rcas_pkg::BTN_XRST]
		| ctrl_wr[rcas_pkg::CTRL_RESET];
	assign test_start = (bif.long_rel_p[rcas_pkg::BTN_UP] | bif.long_rel_p[rcas_pkg::BTN_XTEST])
		&& state == rcas_pkg::ST_RUN;

	assign bus_req = cyc_i && stb_i && !ack_o;
	assign bus_wr  = bus_req && we_i && sel_i == 4'hF;
	assign ctrl_wr = (bus_wr && adr_i == rcas_pkg::REG_CTRL) ? dat_i[3:0] : 4'h0;
	assign cfg_ok  = !pw_en || unlocked;

	////////////////////////////////////////////////////////////////////////
	// sequencing of power-up test and manual test
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state      <= rcas_pkg::ST_POST;
			post_cnt   <= 32'h0;
			inj        <= 1'b0;
			mtest_done <= 1'b0;
		end else begin
			case (state)
				rcas_pkg::ST_POST: begin
					if (bif.tick) begin
						post_cnt <= post_cnt + 32'h1;
					end
					if (bif.tick && post_cnt == 32'(POST_TICKS - 1)) begin
						state <= rcas_pkg::ST_RUN;
					end
				end
				rcas_pkg::ST_RUN: begin
					if (test_start) begin
						state      <= rcas_pkg::ST_MTEST;
						inj        <= 1'b1;
						mtest_done <= 1'b0;
					end else if (reset_req) begin
						mtest_done <= 1'b0;
					end
				end
				rcas_pkg::ST_MTEST: begin
					// injection stops once the relay has dropped, so the contactor can be judged
					if (alarm) begin
						inj <= 1'b0;
					end
					if (alarm && !inj && !clr_run) begin
						state      <= rcas_pkg::ST_RUN;
						mtest_done <= 1'b1;
					end
				end
				default: begin
					state <= rcas_pkg::ST_POST;
					inj   <= 1'b0;
				end
			endcase
		end
	end

	// trip latch: fault memory is always on
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alarm   <= 1'b0;
			alarm_d <= 1'b0;
		end else begin
			alarm_d <= alarm;
			if (over && state != rcas_pkg::ST_POST) begin
				alarm <= 1'b1;
			end else if (reset_req) begin
				alarm <= 1'b0;
			end
		end
	end

	// contactor check after the relay switched
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clr_run  <= 1'b0;
			clr_cnt  <= 16'h0;
			cont_err <= 1'b0;
		end else begin
			if (alarm && !alarm_d) begin
				clr_run <= 1'b1;
				clr_cnt <= 16'h0;
			end else if (clr_run && bif.tick) begin
				if (clr_cnt >= clr_win) begin
					clr_run <= 1'b0;
					if (meas_over) begin
						cont_err <= 1'b1;
					end
				end else begin
					clr_cnt <= clr_cnt + 16'h1;
				end
			end
			if (reset_req && !meas_over && !clr_run) begin
				cont_err <= 1'b0;
			end
		end
	end

	// transformer connection check, latched until reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ct_cnt  <= 32'h0;
			ct_err  <= 1'b0;
			ct_code <= rcas_pkg::ERR_NONE;
		end else begin
			if (bif.tick) begin
				ct_cnt <= (ct_cnt == 32'(CT_TICKS - 1)) ? 32'h0 : ct_cnt + 32'h1;
			end
			if (bif.tick && ct_cnt == 32'(CT_TICKS - 1) && (ct_short_i || ct_open_i)) begin
				ct_err  <= 1'b1;
				ct_code <= ct_short_i ? rcas_pkg::ERR_SHORT : rcas_pkg::ERR_OPEN;
			end else if (reset_req) begin
				ct_err  <= 1'b0;
				ct_code <= rcas_pkg::ERR_NONE;
			end
		end
	end

	// internal faults from power-up, automatic and manual
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			auto_cnt <= 32'h0;
			int_err  <= 1'b0;
		end else begin
			if (bif.tick) begin
				auto_cnt <= (auto_cnt == 32'(AUTO_TICKS - 1)) ? 32'h0 : auto_cnt + 32'h1;
			end
			if (int_fault_i && ((bif.tick && auto_cnt == 32'(AUTO_TICKS - 1))
				|| state != rcas_pkg::ST_RUN)) begin
				int_err <= 1'b1;
			end else if (!int_fault_i) begin
				int_err <= 1'b0; // code stays only while the fault persists
			end
		end
	end

	// display selection and menu entry
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			quick <= 1'b0;
			menu  <= 1'b0;
		end else begin
			if (bif.long_p[rcas_pkg::BTN_ENTER]) begin
				menu  <= ~menu;
				quick <= 1'b0;
			end else if (!menu && (bif.short_p[rcas_pkg::BTN_UP]
				|| bif.short_p[rcas_pkg::BTN_DOWN])) begin
				quick <= 1'b1;
			end else if (bif.short_p[rcas_pkg::BTN_ENTER]) begin
				quick <= 1'b0;
			end
		end
	end

	always_comb begin
		if (state != rcas_pkg::ST_POST && (int_err || ct_err || cont_err)) begin
			disp = rcas_pkg::DSP_ERROR;
		end else if (bif.long_held[rcas_pkg::BTN_UP] || bif.long_held[rcas_pkg::BTN_XTEST]) begin
			disp = rcas_pkg::DSP_ALLSEG;
		end else if (state == rcas_pkg::ST_MTEST) begin
			disp = rcas_pkg::DSP_TEST;
		end else if (quick) begin
			disp = rcas_pkg::DSP_THRESH;
		end else begin
			disp = rcas_pkg::DSP_MEAS;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// settings, password and history
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clr_win  <= rcas_pkg::CLR_WIN_DEF;
			dev_addr <= rcas_pkg::ADDR_DEF;
			pw_val   <= rcas_pkg::PW_DEF;
			pw_en    <= 1'b0;
			unlocked <= 1'b0;
		end else if (ctrl_wr[rcas_pkg::CTRL_FACTORY] && cfg_ok) begin
			clr_win <= rcas_pkg::CLR_WIN_DEF;
			pw_val  <= rcas_pkg::PW_DEF;
			pw_en   <= 1'b0;
		end else if (ctrl_wr[rcas_pkg::CTRL_LOCK]) begin
			unlocked <= 1'b0;
		end else if (bus_wr && adr_i == rcas_pkg::REG_PWKEY) begin
			unlocked <= dat_i[9:0] == pw_val;
		end else if (bus_wr && cfg_ok && adr_i == rcas_pkg::REG_CFG) begin
			clr_win  <= dat_i[15:0];
			dev_addr <= dat_i[23:16];
		end else if (bus_wr && cfg_ok && adr_i == rcas_pkg::REG_PWSET
			&& dat_i[9:0] <= rcas_pkg::PW_MAX) begin
			pw_val <= dat_i[9:0];
			pw_en  <= dat_i[rcas_pkg::PWSET_EN];
		end
	end

	// only the first trip is kept; a capture in the clearing cycle wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hist_val <= 16'h0;
			hist_vld <= 1'b0;
		end else if (alarm && !alarm_d && !hist_vld) begin
			hist_val <= eval_ua[15:0];
			hist_vld <= 1'b1;
		end else if (ctrl_wr[rcas_pkg::CTRL_HCLR]) begin
			hist_vld <= 1'b0;
			hist_val <= 16'h0;
		end
	end

	// wishbone answer one cycle after the request; unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0;
		end else begin
			ack_o <= bus_req;
			dat_o <= 32'h0;
			if (bus_req && !we_i) begin
				case (adr_i)
					rcas_pkg::REG_STATUS: dat_o <= {16'h0, mtest_done, unlocked,
						state, err_code_o, menu, int_err, ct_err, cont_err,
						alarm, alarm_relay_o, trip_lamp_o, err_lamp_o};
					rcas_pkg::REG_MEAS:   dat_o <= {16'h0, residual_ua_i};
					rcas_pkg::REG_HIST:   dat_o <= {hist_vld, 15'h0, hist_val};
					rcas_pkg::REG_CFG:    dat_o <= {8'h0, dev_addr, clr_win};
					rcas_pkg::REG_PWSET:  dat_o <= {15'h0, pw_en, 6'h0, pw_val};
					default:              dat_o <= 32'h0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// registered pin outputs; relay energised means no alarm
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			alarm_relay_o <= 1'b0;
			trip_lamp_o   <= 1'b1;
			err_lamp_o    <= 1'b0;
			test_inject_o <= 1'b0;
			menu_mode_o   <= 1'b0;
			disp_sel_o    <= 3'h0;
			disp_value_o  <= 16'h0;
			err_code_o    <= rcas_pkg::ERR_NONE;
		end else begin
			if (state == rcas_pkg::ST_POST) begin
				alarm_relay_o <= 1'b0;
				trip_lamp_o   <= 1'b1;
				err_lamp_o    <= bif.flash;
			end else begin
				alarm_relay_o <= !(alarm || ct_err || int_err);
				trip_lamp_o   <= alarm || ct_err || int_err;
				err_lamp_o    <= (ct_err || cont_err || int_err) && bif.flash;
			end
			test_inject_o <= inj;
			menu_mode_o   <= menu;
			disp_sel_o    <= disp;
			disp_value_o  <= quick ? rcas_pkg::TRIP_UA[15:0] : residual_ua_i;
			if (int_err) begin
				err_code_o <= rcas_pkg::ERR_INT;
			end else if (ct_err) begin
				err_code_o <= ct_code;
			end else if (cont_err) begin
				err_code_o <= rcas_pkg::ERR_CONT;
			end else begin
				err_code_o <= rcas_pkg::ERR_NONE;
			end
		end
	end
endmodule
`default_nettype wire

/* File: sim/rcas_checker.sv */
// checker: port-level properties of the supervisor
`timescale 1ns/1ps
`default_nettype none
module rcas_checker (
	// clock and reset
	input wire logic        clk_i,
	input wire logic        rst_i,
	// bus
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic        ack_o,
	input wire logic [31:0] dat_o,
	// measurement and outputs
	input wire logic [15:0] residual_ua_i,
	input wire logic        alarm_relay_o,
	input wire logic        trip_lamp_o,
	input wire logic        err_lamp_o,
	input wire logic        test_inject_o,
	input wire logic [2:0]  disp_sel_o,
	input wire logic [15:0] disp_value_o,
	input wire logic [3:0]  err_code_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////
	property p_ack;
		cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o;
	endproperty
	a_ack: assert property (p_ack) else $error("ack not a single cycle");
	property p_rdz;
		!ack_o |-> dat_o == 32'h0;
	endproperty
	a_rdz: assert property (p_rdz) else $error("read data outside ack");
	property p_trip;
		residual_ua_i > 16'h1770 |-> ##[1:2] (!alarm_relay_o && trip_lamp_o);
	endproperty
	a_trip: assert property (p_trip) else $error("no trip on overcurrent");
	property p_safe;
		alarm_relay_o |-> !trip_lamp_o;
	endproperty
	a_safe: assert property (p_safe) else $error("relay normal while lit");
	property p_thr;
		disp_sel_o == 3'h1 |-> disp_value_o == 16'h1770;
	endproperty
	a_thr: assert property (p_thr) else $error("wrong threshold shown");
	// one cycle of slack: code and lamp may land on neighbouring edges
	property p_etrip;
		$past(err_code_o) != 4'h0 && err_code_o != 4'h0 |-> trip_lamp_o;
	endproperty
	a_etrip: assert property (p_etrip) else $error("error without trip");
	property p_tsym;
		$rose(test_inject_o) |-> disp_sel_o == 3'h3;
	endproperty
	a_tsym: assert property (p_tsym) else $error("test symbol missing");
	property p_ttrip;
		$rose(test_inject_o) |-> ##[1:3] (!alarm_relay_o && trip_lamp_o);
	endproperty
	a_ttrip: assert property (p_ttrip) else $error("test did not trip");
	property p_flash;
		$changed(err_lamp_o) |=> $stable(err_lamp_o) [*8];
	endproperty
	a_flash: assert property (p_flash) else $error("error lamp too fast");
	c_trip: cover property ($fell(alarm_relay_o));
	c_test: cover property ($rose(test_inject_o));
	c_cont: cover property (err_code_o == 4'h4);
endmodule
bind rcas_top rcas_checker i_rcas_checker (.clk_i, .rst_i, .cyc_i, .stb_i, .ack_o, .dat_o,
	.residual_ua_i, .alarm_relay_o, .trip_lamp_o, .err_lamp_o, .test_inject_o,
	.disp_sel_o, .disp_value_o, .err_code_o);
`default_nettype wire

/* File: sim/rcas_load.sv */
// load model: leakage through the contactor driven by the alarm relay
`timescale 1ns/1ps
`default_nettype none
module rcas_load (
	// clock
	input  wire logic        clk_i,
	// coil and scenario controls
	input  wire logic        relay_i,
	input  wire logic [15:0] leak_i,
	input  wire logic        stuck_i,
	// measured current
	output logic      [15:0] res_o
);
	logic [1:0] dly = 2'h0;
	// contactor opens a few cycles after the coil drops; a welded one never does
	always_ff @(posedge clk_i) begin
		dly <= relay_i ? 2'h0 : ((dly == 2'h3) ? dly : dly + 2'h1);
	end
	assign res_o = (dly == 2'h3 && !stuck_i) ? 16'h0000 : leak_i;
endmodule
`default_nettype wire

/* File: sim/rcas_top_tb.sv */
// testbench: supervisor driven through bus, buttons and load model
`timescale 1ns/1ps
`default_nettype none
module rcas_top_tb;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        cyc = 1'b0;
	logic        stb = 1'b0;
	logic        we = 1'b0;
	logic [7:0]  adr = 8'h00;
	logic [31:0] wd = 32'h0;
	logic [3:0]  sel = 4'hF;
	logic [31:0] rd;
	logic [31:0] q;
	logic        ack;
	logic [15:0] res;
	logic [15:0] leak = 16'h0000;
	logic        stuck = 1'b0;
	logic        cts = 1'b0;
	logic        cto = 1'b0;
	logic        intf = 1'b0;
	logic [4:0]  btn = 5'h00;
	logic        relay;
	logic        trip;
	logic        errl;
	logic [2:0]  dsel;
	logic [15:0] dval;
	logic [3:0]  ecode;
	logic        tinj;
	logic        menu;
	int          failures = 0;
	int          n_checks = 0;
	int          n;

	always #50 clk = ~clk;

	rcas_top #(.TICK_CYC(4), .LONG_TICKS(10), .DEB_TICKS(2), .CT_TICKS(50),
		.AUTO_TICKS(200), .POST_TICKS(5)) i_rcas_top (.clk_i(clk), .rst_i(rst),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wd),
		.dat_o(rd), .ack_o(ack), .residual_ua_i(res), .ct_short_i(cts), .ct_open_i(cto),
		.int_fault_i(intf), .btn_up_i(btn[0]), .btn_down_i(btn[1]), .btn_enter_i(btn[2]),
		.ext_test_i(btn[3]), .ext_reset_i(btn[4]), .alarm_relay_o(relay),
		.trip_lamp_o(trip), .err_lamp_o(errl), .test_inject_o(tinj), .menu_mode_o(menu),
		.disp_sel_o(dsel), .disp_value_o(dval), .err_code_o(ecode));
	rcas_load i_rcas_load (.clk_i(clk), .relay_i(relay), .leak_i(leak), .stuck_i(stuck),
		.res_o(res));
	////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic ticks(input int k);
		repeat (k * 4) @(posedge clk);
	endtask
	task automatic press(input int b, input int k);
		btn[b] <= 1'b1;
		ticks(k);
		btn[b] <= 1'b0;
		ticks(6);
	endtask
	// classic single cycle; held until ack is seen, then one idle cycle
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wd <= d;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rd;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
		if (k >= 20) begin
			failures++;
			tally_and_finish();
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({relay, trip}, 2'b01);
		ticks(10);
		chk({relay, trip, errl}, 3'b100);
		wb(1'b1, 8'h10, 32'h00030014);
		wb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h00030014);
		wb(1'b0, 8'h40, 32'h0);
		chk(q, 32'h0);
		$display("power-up and registers done");
		leak <= 16'h1B58;
		ticks(2);
		chk({relay, trip}, 2'b01);
		leak <= 16'h0000;
		ticks(5);
		chk({relay, trip}, 2'b01);
		wb(1'b0, 8'h0C, 32'h0);
		chk(q, 32'h80001B58);
		press(1, 20);
		chk({relay, trip}, 2'b10);
		leak <= 16'h1F40;
		ticks(2);
		leak <= 16'h0000;
		wb(1'b0, 8'h0C, 32'h0);
		chk(q, 32'h80001B58);
		wb(1'b1, 8'h00, 32'h00000005);
		wb(1'b0, 8'h0C, 32'h0);
		chk(q[31], 1'b0);
		chk({relay, trip}, 2'b10);
		$display("trip and latch done");
		stuck <= 1'b1;
		leak <= 16'h1B58;
		ticks(10);
		chk(ecode, 4'h0);
		ticks(20);
		chk({relay, trip, ecode}, 6'h14);
		stuck <= 1'b0;
		leak <= 16'h0000;
		press(4, 20);
		chk({relay, ecode}, 5'h10);
		$display("contactor done");
		for (int i = 0; i < 2; i++) begin
			cts <= (i == 0);
			cto <= (i == 1);
			ticks(60);
			chk({relay, trip, ecode}, {2'b01, (i == 0) ? 4'h1 : 4'h3});
			cts <= 1'b0;
			cto <= 1'b0;
			ticks(60);
			chk({relay, trip}, 2'b01);
			press((i == 0) ? 1 : 4, 20);
			chk({relay, trip}, 2'b10);
		end
		$display("transformer done");
		for (int i = 0; i < 2; i++) begin
			press(i, 5);
			chk({dsel, dval}, {3'h1, 16'h1770});
			press(2, 5);
			chk(dsel, 3'h0);
		end
		// long enter opens the menu, where a short up must not show the threshold
		press(2, 20);
		press(0, 5);
		chk({menu, dsel}, 4'h8);
		press(2, 20);
		chk(menu, 1'b0);
		$display("quick query done");
		for (int i = 0; i < 2; i++) begin
			btn[(i == 0) ? 0 : 3] <= 1'b1;
			ticks(15);
			chk(dsel, 3'h2);
			btn <= 5'h00;
			n = 0;
			while (dsel !== 3'h3 && n < 80) begin
				@(posedge clk);
				n++;
			end
			chk({dsel, tinj}, {3'h3, 1'b1});
			// second pass: a welded contactor keeps the leak flowing after the relay drops
			if (i == 1) begin
				stuck <= 1'b1;
				leak  <= 16'h1B58;
			end
			ticks(2);
			chk({relay, trip, tinj}, 3'b010);
			ticks(25);
			wb(1'b0, 8'h04, 32'h0);
			chk({q[15], q[11:8]}, (i == 0) ? 5'h10 : 5'h14);
			stuck <= 1'b0;
			leak  <= 16'h0000;
			press(1, 20);
			chk({relay, trip}, 2'b10);
		end
		$display("manual test done");
		intf <= 1'b1;
		ticks(210);
		chk({trip, tinj, ecode}, 6'h25);
		intf <= 1'b0;
		ticks(2);
		chk(ecode, 4'h0);
		press(1, 20);
		$display("internal fault done");
		// a write without all byte lanes must leave the settings alone
		sel <= 4'h3;
		wb(1'b1, 8'h10, 32'h00070030);
		sel <= 4'hF;
		wb(1'b1, 8'h14, 32'h00010005);
		wb(1'b1, 8'h10, 32'h00070030);
		wb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h00030014);
		wb(1'b1, 8'h18, 32'h00000005);
		wb(1'b1, 8'h10, 32'h00070030);
		wb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h00070030);
		wb(1'b1, 8'h00, 32'h00000002);
		wb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h000700C8);
		$display("password done");
		tally_and_finish();
	end
	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
